// ### include/synth_cfg_map.svh
// Field positions, select codes and widths of the synthesizer configuration words.
`ifndef SYNTH_CFG_MAP_SVH
`define SYNTH_CFG_MAP_SVH
`define SER_WORD_W 24
`define SEL_W 3
`define SEL_RF_FEEDBACK 3'h0
`define SEL_RF_REFERENCE 3'h1
`define SEL_RF_CONTROL 3'h2
`define SEL_IF_REFERENCE 3'h5
`define SEL_IF_CONTROL 3'h6
`define FB_FEEDBACK_FRACTION_LSB 3
`define FB_FEEDBACK_FRACTION_MSB 14
`define FB_INT_LSB 15
`define FB_INT_MSB 22
`define RR_MOD_LSB 3
`define RR_MOD_MSB 14
`define RR_COUNT_LSB 15
`define RR_COUNT_MSB 18
`define RR_DOUBLER_BIT 19
`define RR_PRESCALER_BIT 20
`define RF_CTRL_W 16
`define IFR_COUNT_LSB 3
`define IFR_COUNT_MSB 17
`define IFR_DOUBLER_BIT 18
`define IFR_W 19
`define IFC_W 16
`define IFC_HOLD_BIT 3
`define IFC_HIZ_BIT 4
`define IFC_SLEEP_BIT 5
`define IFC_LDP_BIT 6
`define IFC_SENSE_BIT 7
`define IFC_CP_LSB 8
`define IFC_CP_MSB 10
`define IFC_PR1_BIT 11
`define IFC_T7_BIT 12
`define IFC_T8_BIT 13
`define IFC_PR2_BIT 14
`define IFC_PR3_BIT 15
`define PRESCALER_LOW 4'h4
`define PRESCALER_HIGH 4'h8
`endif

// ### include/synth_cfg_pkg.sv
// Types shared by the synthesizer configuration bank.
package synth_cfg_pkg;
  typedef logic [23:0] ser_word_t;
  typedef logic [2:0] sel_t;
  typedef logic [6:0] pump_level_t;
endpackage : synth_cfg_pkg

// ### logic/ref_divider.sv
// Reference edge selector, optional doubler and programmable divider.
module ref_divider #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ref_level,
  input wire logic doubler,
  input wire logic [W-1:0] ratio,
  input wire logic hold,
  output logic cmp_pulse
);
  logic ref_q_ff;
  logic [W-1:0] cnt_ff;
  logic cmp_pulse_ff;
  logic rise;
  logic fall;
  logic active;
  logic last;

  assign rise = ref_level & ~ref_q_ff;
  assign fall = ~ref_level & ref_q_ff;
  // Doubling is modelled by counting both edges; plain mode counts only the falling one.
  assign active = doubler ? (rise | fall) : fall;
  // A ratio of zero behaves as one so the counter can never run away.
  assign last = ({1'b0, cnt_ff} + {{W{1'b0}}, 1'b1}) >= {1'b0, ratio};
  assign cmp_pulse = cmp_pulse_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_q_ff <= 1'b0;
    end else begin
      ref_q_ff <= ref_level;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      cmp_pulse_ff <= 1'b0;
    end else if (hold) begin
      cnt_ff <= '0;
      cmp_pulse_ff <= 1'b0;
    end else if (active && last) begin
      cnt_ff <= '0;
      cmp_pulse_ff <= 1'b1;
    end else if (active) begin
      cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
      cmp_pulse_ff <= 1'b0;
    end else begin
      cmp_pulse_ff <= 1'b0;
    end
  end
endmodule : ref_divider

// ### logic/synth_cfg_regs.sv
// Serial-loaded configuration register bank of a dual RF/IF synthesizer.
// Summary of operation
// - A word ending in select 000 loads the RF feedback register.
// - A word ending in select 001 loads the RF reference register.
// - A word ending in select 010 loads the RF control register.
// - A word with select 110 loads the sixteen-bit IF control register.
// - An eight-bit integer field forms the integer part of feedback division.
// - A twelve-bit fractional modulus is held in the reference register.
// - RF doubler bit off passes reference directly; on doubles it first.
// - Doubler off uses falling edges only; doubler on uses both edges.
// - The four-bit RF counter divides the reference by 1 to 15.
// - RF feedback ratio comes from prescaler, integer, fraction and modulus.
// - IF counter-hold bit set keeps the IF counters in reset.
// - IF pump high-impedance bit set floats the IF charge pump.
// - IF sleep bit set powers down the IF section.
// - IF detector sense bit selects negative at 0, positive at 1.
// - Three-bit IF pump current code gives eight monotonic settings.
// - Three-bit resync field: all zeros disables, all ones enables.
// - A word ending in select 101 loads the IF reference register.
// - The fifteen-bit IF counter divides the reference by 1 to 32767.
// - IF doubler bit off passes reference directly; on doubles it first.
`include "synth_cfg_map.svh"
module synth_cfg_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_load,
  input wire logic reference_input,
  output logic [7:0] fb_integer,
  output logic [11:0] feedback_fraction,
  output logic [11:0] fraction_modulus,
  output logic [3:0] prescaler_value,
  output logic rf_doubler,
  output logic [3:0] rf_ref_count,
  output logic [15:0] rf_control_word,
  output logic rf_cmp_pulse,
  output logic [14:0] if_ref_count,
  output logic if_doubler_bit,
  output logic if_counter_hold_bit,
  output logic if_pump_hiz_bit,
  output logic if_sleep_bit,
  output logic if_lock_precision_bit,
  output logic if_detector_sense_bit,
  output logic [2:0] pump_current,
  output synth_cfg_pkg::pump_level_t pump_level,
  output logic [2:0] resync_code,
  output logic resync_enable,
  output logic [1:0] test_bits,
  output logic if_cmp_pulse
);
  import synth_cfg_pkg::*;

  ser_word_t shift_ff;
  logic ser_clk_q_ff;
  logic ser_load_q_ff;
  ser_word_t rf_feedback_word_ff;
  ser_word_t rf_reference_word_ff;
  logic [`RF_CTRL_W-1:0] rf_control_word_ff;
  logic [`IFR_W-1:0] if_reference_divider_ff;
  logic [`IFC_W-1:0] if_loop_control_ff;
  logic [3:0] prescaler_value_ff;
  pump_level_t pump_level_ff;
  logic resync_enable_ff;
  logic [3:0] nxt_prescaler_value;
  pump_level_t nxt_pump_level;
  logic shift_en;
  logic latch_en;
  sel_t sel;

  assign shift_en = ser_clk & ~ser_clk_q_ff;
  assign latch_en = ser_load & ~ser_load_q_ff;
  assign sel = shift_ff[`SEL_W-1:0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ser_clk_q_ff <= 1'b0;
      ser_load_q_ff <= 1'b0;
    end else begin
      ser_clk_q_ff <= ser_clk;
      ser_load_q_ff <= ser_load;
    end
  end

  // Data enters most significant bit first, so short words land in the low bits.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_ff <= '0;
    end else if (shift_en) begin
      shift_ff <= {shift_ff[`SER_WORD_W-2:0], ser_data};
    end
  end

  // Each target moves only on the load edge with its own select code.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rf_feedback_word_ff <= '0;
    end else if (latch_en && sel == `SEL_RF_FEEDBACK) begin
      rf_feedback_word_ff <= shift_ff;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rf_reference_word_ff <= '0;
    end else if (latch_en && sel == `SEL_RF_REFERENCE) begin
      rf_reference_word_ff <= shift_ff;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rf_control_word_ff <= '0;
    end else if (latch_en && sel == `SEL_RF_CONTROL) begin
      rf_control_word_ff <= shift_ff[`RF_CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      if_reference_divider_ff <= '0;
    end else if (latch_en && sel == `SEL_IF_REFERENCE) begin
      if_reference_divider_ff <= shift_ff[`IFR_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      if_loop_control_ff <= '0;
    end else if (latch_en && sel == `SEL_IF_CONTROL) begin
      if_loop_control_ff <= shift_ff[`IFC_W-1:0];
    end
  end

  // The enable has its own flop so that the output needs no gate after the register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resync_enable_ff <= 1'b0;
    end else if (latch_en && sel == `SEL_IF_CONTROL) begin
      resync_enable_ff <= shift_ff[`IFC_PR3_BIT] & shift_ff[`IFC_PR2_BIT] &
        shift_ff[`IFC_PR1_BIT];
    end
  end

  // Prescaler modulus and pump level are re-derived every cycle, one cycle behind the word.
  always_comb begin
    nxt_prescaler_value = rf_reference_word_ff[`RR_PRESCALER_BIT] ?
      `PRESCALER_HIGH : `PRESCALER_LOW;
  end

  // A thermometer code makes the current rise by one step per code value.
  for (genvar g = 0; g < 7; g++) begin : g_pump_level
    assign nxt_pump_level[g] = (if_loop_control_ff[`IFC_CP_MSB:`IFC_CP_LSB] > 3'(g));
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prescaler_value_ff <= `PRESCALER_LOW;
    end else begin
      prescaler_value_ff <= nxt_prescaler_value;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pump_level_ff <= '0;
    end else begin
      pump_level_ff <= nxt_pump_level;
    end
  end

  // Integer, fraction and modulus leave straight from the words, the prescaler one cycle later; together they set the feedback ratio.
  assign fb_integer = rf_feedback_word_ff[`FB_INT_MSB:`FB_INT_LSB];
  assign feedback_fraction = rf_feedback_word_ff[`FB_FEEDBACK_FRACTION_MSB:`FB_FEEDBACK_FRACTION_LSB];
  assign fraction_modulus = rf_reference_word_ff[`RR_MOD_MSB:`RR_MOD_LSB];
  assign prescaler_value = prescaler_value_ff;
  assign rf_doubler = rf_reference_word_ff[`RR_DOUBLER_BIT];
  assign rf_ref_count = rf_reference_word_ff[`RR_COUNT_MSB:`RR_COUNT_LSB];
  assign rf_control_word = rf_control_word_ff;
  assign if_ref_count = if_reference_divider_ff[`IFR_COUNT_MSB:`IFR_COUNT_LSB];
  assign if_doubler_bit = if_reference_divider_ff[`IFR_DOUBLER_BIT];
  assign if_counter_hold_bit = if_loop_control_ff[`IFC_HOLD_BIT];
  assign if_pump_hiz_bit = if_loop_control_ff[`IFC_HIZ_BIT];
  assign if_sleep_bit = if_loop_control_ff[`IFC_SLEEP_BIT];
  assign if_lock_precision_bit = if_loop_control_ff[`IFC_LDP_BIT];
  assign if_detector_sense_bit = if_loop_control_ff[`IFC_SENSE_BIT];
  assign pump_current = if_loop_control_ff[`IFC_CP_MSB:`IFC_CP_LSB];
  assign pump_level = pump_level_ff;
  assign resync_code = {if_loop_control_ff[`IFC_PR3_BIT], if_loop_control_ff[`IFC_PR2_BIT],
    if_loop_control_ff[`IFC_PR1_BIT]};
  // Mixed resync codes are left disabled, since only all ones is a defined enable.
  assign resync_enable = resync_enable_ff;
  assign test_bits = {if_loop_control_ff[`IFC_T8_BIT], if_loop_control_ff[`IFC_T7_BIT]};

  ref_divider #(
    .W(4)
  ) u_rf_ref (
    .clk(clk),
    .nrst(nrst),
    .ref_level(reference_input),
    .doubler(rf_doubler),
    .ratio(rf_ref_count),
    .hold(1'b0),
    .cmp_pulse(rf_cmp_pulse)
  );

  // Sleep also holds the IF divider in reset, since a powered-down section must not count.
  ref_divider #(
    .W(15)
  ) u_if_ref (
    .clk(clk),
    .nrst(nrst),
    .ref_level(reference_input),
    .doubler(if_doubler_bit),
    .ratio(if_ref_count),
    .hold(if_counter_hold_bit | if_sleep_bit),
    .cmp_pulse(if_cmp_pulse)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_load(logic [2:0] code);
    latch_en && sel == code;
  endsequence

  // The pulse trails its edge by one cycle, hence the two-deep look back.
  sequence s_ref_fall;
    $past(reference_input, 2) && !$past(reference_input);
  endsequence

  sequence s_ref_any(logic dbl);
    $past(dbl) && ($past(reference_input, 2) != $past(reference_input));
  endsequence

  sequence s_stray_load;
    latch_en && (sel == 3'h3 || sel == 3'h4 || sel == 3'h7);
  endsequence

  a_feedback_load: assert property (s_load(`SEL_RF_FEEDBACK) |=>
    rf_feedback_word_ff == $past(shift_ff)) else $error("feedback word not loaded");
  a_reference_load: assert property (s_load(`SEL_RF_REFERENCE) |=>
    fraction_modulus == $past(shift_ff[14:3])) else $error("reference word not loaded");
  a_control_load: assert property (s_load(`SEL_RF_CONTROL) |=>
    rf_control_word == $past(shift_ff[15:0])) else $error("control word not loaded");
  a_if_ctrl_load: assert property (s_load(`SEL_IF_CONTROL) |=>
    if_loop_control_ff == $past(shift_ff[15:0])) else $error("IF control not loaded");
  a_if_ref_load: assert property (s_load(`SEL_IF_REFERENCE) |=>
    if_ref_count == $past(shift_ff[17:3])) else $error("IF reference not loaded");
  a_words_retain: assert property (!latch_en |=> $stable(rf_feedback_word_ff) &&
    $stable(if_loop_control_ff) && $stable(if_reference_divider_ff))
    else $error("register changed without a load");
  a_integer_field: assert property (s_load(`SEL_RF_FEEDBACK) |=>
    fb_integer == $past(shift_ff[22:15])) else $error("integer field wrong");
  a_if_hold_quiet: assert property ((if_counter_hold_bit || if_sleep_bit)[*2] |->
    !if_cmp_pulse) else $error("IF divider ran while held");
  a_resync_enable: assert property (resync_enable == (resync_code == 3'h7))
    else $error("resync enable wrong");
  a_pump_monotone: assert property ($stable(pump_current) |->
    $countones(pump_level) == pump_current) else $error("pump level decode wrong");

  a_fraction_field: assert property (s_load(`SEL_RF_FEEDBACK) |=>
    feedback_fraction == $past(shift_ff[14:3])) else $error("fraction field wrong");
  a_ref_fields: assert property (s_load(`SEL_RF_REFERENCE) |=>
    rf_doubler == $past(shift_ff[19]) && rf_ref_count == $past(shift_ff[18:15]))
    else $error("reference fields wrong");
  a_prescaler_pick: assert property (s_load(`SEL_RF_REFERENCE) ##1 1'b1 |=>
    prescaler_value == ($past(shift_ff[20], 2) ? `PRESCALER_HIGH : `PRESCALER_LOW))
    else $error("prescaler modulus wrong");
  a_if_doubler: assert property (s_load(`SEL_IF_REFERENCE) |=>
    if_doubler_bit == $past(shift_ff[18])) else $error("IF doubler bit wrong");
  a_if_flags: assert property (s_load(`SEL_IF_CONTROL) |=>
    {if_detector_sense_bit, if_lock_precision_bit, if_sleep_bit, if_pump_hiz_bit,
    if_counter_hold_bit} == $past(shift_ff[7:3])) else $error("IF flag bits wrong");
  a_pump_field: assert property (s_load(`SEL_IF_CONTROL) |=>
    pump_current == $past(shift_ff[10:8])) else $error("pump current field wrong");
  a_resync_load: assert property (s_load(`SEL_IF_CONTROL) |=>
    resync_enable == ($past(shift_ff[15:14]) == 2'h3 && $past(shift_ff[11])))
    else $error("resync enable not loaded");

  a_stray_ignored: assert property (s_stray_load |=> $stable(rf_feedback_word_ff) &&
    $stable(rf_reference_word_ff) && $stable(rf_control_word_ff) &&
    $stable(if_reference_divider_ff) && $stable(if_loop_control_ff))
    else $error("unknown select changed a register");
  a_rf_words_keep: assert property (!latch_en |=> $stable(rf_reference_word_ff) &&
    $stable(rf_control_word_ff)) else $error("RF word changed without a load");
  a_control_only: assert property (s_load(`SEL_RF_CONTROL) |=>
    $stable(rf_feedback_word_ff) && $stable(if_loop_control_ff))
    else $error("control load touched another register");
  a_if_ctrl_only: assert property (s_load(`SEL_IF_CONTROL) |=>
    $stable(rf_reference_word_ff) && $stable(if_reference_divider_ff))
    else $error("IF control load touched another register");
  a_shift_step: assert property (shift_en |=>
    shift_ff == {$past(shift_ff[22:0]), $past(ser_data)}) else $error("shift step wrong");
  a_shift_quiet: assert property (!shift_en |=> $stable(shift_ff))
    else $error("shift register moved without a clock");

  a_rf_edge_src: assert property (rf_cmp_pulse |->
    (s_ref_fall or s_ref_any(rf_doubler))) else $error("RF pulse without an active edge");
  a_if_edge_src: assert property (if_cmp_pulse |->
    (s_ref_fall or s_ref_any(if_doubler_bit))) else $error("IF pulse without an active edge");
endmodule : synth_cfg_regs

// ### verif/serial_host.sv
// Behavioural model of the host controller that shifts configuration words into the bank.
module serial_host (
  input wire logic clk,
  output logic ser_clk,
  output logic ser_data,
  output logic ser_load
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_load = 1'b0;
  end
  // Sends one word MSB first; gap stretches the pause before the load strobe.
  task automatic send_word(input logic [23:0] w, input int gap);
    for (int i = 23; i >= 0; i--) begin
      @(negedge clk) ser_data = w[i];
      @(negedge clk) ser_clk = 1'b1;
      @(negedge clk) ser_clk = 1'b0;
    end
    // The data line is not held after the frame, so it shows the opposite of the last bit.
    ser_data = ~w[0];
    repeat (gap + 1) @(negedge clk);
    ser_load = 1'b1;
    @(negedge clk) ser_load = 1'b0;
  endtask : send_word
endmodule : serial_host

// ### verif/tb.sv
// Self-checking testbench of the synthesizer configuration bank.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import synth_cfg_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reference_input = 1'b0;
  wire ser_clk, ser_data, ser_load;
  logic [7:0] fb_integer;
  logic [11:0] feedback_fraction, fraction_modulus;
  logic [3:0] prescaler_value, rf_ref_count;
  logic [15:0] rf_control_word;
  logic [14:0] if_ref_count;
  logic [2:0] pump_current, resync_code;
  pump_level_t pump_level;
  logic [1:0] test_bits;
  logic rf_doubler, rf_cmp_pulse, if_doubler_bit, if_counter_hold_bit, if_pump_hiz_bit;
  logic if_sleep_bit, if_lock_precision_bit, if_detector_sense_bit, resync_enable, if_cmp_pulse;
  logic [23:0] w0 = '0, w1 = '0, w2 = '0, w5 = '0, w6 = '0;
  logic [3:0] rt [3] = '{4'h1, 4'hf, 4'h3};
  int errors = 0;
  int samples_checked = 0;
  wire [93:0] regs = {fb_integer, feedback_fraction, fraction_modulus, prescaler_value,
    rf_doubler, rf_ref_count, rf_control_word, if_doubler_bit, if_ref_count,
    if_detector_sense_bit, if_lock_precision_bit, if_sleep_bit, if_pump_hiz_bit,
    if_counter_hold_bit, pump_current, pump_level, resync_code, resync_enable, test_bits};

  serial_host u_host (.clk, .ser_clk, .ser_data, .ser_load);
  synth_cfg_regs u_dut (.clk, .nrst, .ser_clk, .ser_data, .ser_load, .reference_input,
    .fb_integer, .feedback_fraction, .fraction_modulus, .prescaler_value, .rf_doubler,
    .rf_ref_count, .rf_control_word, .rf_cmp_pulse, .if_ref_count, .if_doubler_bit,
    .if_counter_hold_bit, .if_pump_hiz_bit, .if_sleep_bit, .if_lock_precision_bit,
    .if_detector_sense_bit, .pump_current, .pump_level, .resync_code, .resync_enable,
    .test_bits, .if_cmp_pulse);

  always #12.5 clk = ~clk;
  always begin
    repeat (4) @(negedge clk);
    reference_input = ~reference_input;
  end

  function automatic logic [6:0] therm(input logic [2:0] c);
    return 7'((8'h1 << c) - 8'h1);
  endfunction : therm

  function automatic logic [93:0] exp_regs();
    return {w0[22:15], w0[14:3], w1[14:3], w1[20] ? 4'h8 : 4'h4, w1[19:15], w2[15:0],
      w5[18:3], w6[7:3], w6[10:8], therm(w6[10:8]), w6[15:14], w6[11],
      &{w6[15:14], w6[11]}, w6[13:12]};
  endfunction : exp_regs

  function automatic logic [23:0] rnd_word(input logic [2:0] sel);
    logic [23:0] w;
    w = 24'($urandom);
    w[2:0] = sel;
    if (sel == 3'h2) w[15:11] = 5'h0;
    if (sel == 3'h6) w[13:12] = 2'h0;
    if (sel == 3'h0) w[14:3] = 12'($urandom % (32'(w1[14:3]) + 1));
    if (sel == 3'h1) w[14:3] = 12'(w0[14:3] + $urandom % (4096 - 32'(w0[14:3])));
    return w;
  endfunction : rnd_word

  task automatic chk_regs(input logic [93:0] got, input logic [93:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_regs

  // A divider's phase at the window start is unknown, so one pulse of slack is allowed unless zero pulses are expected.
  task automatic chk_cnt(input logic [31:0] got, input int exp);
    samples_checked++;
    if (^got === 1'bx || int'(got) > exp + (exp != 0) || int'(got) < exp - (exp != 0)) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_cnt

  // Unknown selects leave every shadow as it was.
  task automatic put(input logic [23:0] w);
    u_host.send_word(w, int'($urandom_range(3)));
    case (w[2:0])
      3'h0: w0 = w;
      3'h1: w1 = w;
      3'h2: w2 = w;
      3'h5: w5 = w;
      3'h6: w6 = w;
      default: ;
    endcase
    repeat (3) @(negedge clk);
    chk_regs(regs, exp_regs());
  endtask : put

  task automatic count_pulses(input bit rf, input int exp);
    logic [31:0] n;
    n = '0;
    repeat (16) @(negedge clk);
    repeat (480) @(negedge clk) n += {31'h0, rf ? rf_cmp_pulse : if_cmp_pulse};
    chk_cnt(n, exp);
  endtask : count_pulses

  task automatic tally_and_finish;
    if (errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    #750us;
    errors++;
    tally_and_finish;
  end

  initial begin
    void'($urandom(32'hc02c449f));
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    chk_regs(regs, exp_regs());
    for (int i = 0; i < 40; i++) put(rnd_word(3'(i)));
    foreach (rt[k]) for (int d = 0; d < 2; d++) begin
      put({3'h0, 1'b1, d[0], rt[k], 12'hfff, 3'h1});
      count_pulses(1'b1, (60 << d) / int'(rt[k]));
    end
    put({5'h0, 1'b1, 15'h5, 3'h5});
    put(24'h00000e);
    count_pulses(1'b0, 0);
    put(24'h000026);
    count_pulses(1'b0, 0);
    put(24'h000006);
    count_pulses(1'b0, 24);
    tally_and_finish;
  end
endmodule : tb
